/* File: iocsp_top.sv */
// Function
// - keyboard code is 8 bits: 6 key id, 1 spare, 1 up/down
// - a code arrives on press and on release, no key decoding
// - keyboard strobe drives counter-timer channel 2 trigger
// - reading keyboard data port clears keyboard ready flag
// - keyboard reset active after reset; release makes keyboard list held keys
// - page-select bits reset to zero, selecting map 0
// - ports 0-3 at 18H-1BH, port 5 at 1DH, display at 0-17H
// - port 0 write stores bits 3:0 to map entry chosen by upper address
// - port 1 write: network, kbd reset, handshakes, single step, pages
// - port 1 read: network, user ready, handshake in, kbd ready, blanks
// - port 2 read: buttons, timers, serial rx, cts, cassette level, data
// - port 2 write: column, alt chars, speaker, trigger, tx, modes, wren
// - cassette tone from channel 1, then divided by two for square wave
// - cassette output reaches recorder only while write enable bit is zero
// - cassette level input pin is readable by host; the divider output is not
// - rising trigger edge fires both joystick monostables, read as timers
// - user strobe rising edge latches data, sets ready and busy
// - host read of user port clears ready and busy
// - while user strobe low the user port is transparent
// - frame blanking clocks counter-timer channel 4
`timescale 1ns/1ns
`default_nettype none
module iocsp_top #(
	parameter int JOY_CYC = iocsp_pkg::JOY_MONO_CYC,
	parameter int KFIFO_DEPTH = 8
) (
	// clock and reset
	input  wire logic                   clk_i,
	input  wire logic                   reset_n_i,
	// host i/o bus
	input  wire iocsp_pkg::iocsp_bus_t  bus_i,
	output logic                 [7:0]  rdata_o,
	output logic                        rdata_valid_o,
	output iocsp_pkg::iocsp_sel_t       sel_o,
	// keyboard
	input  wire logic            [7:0]  kbd_code_i,
	input  wire logic                   kbd_strobe_i,
	output logic                        kbd_reset_o,
	output logic                        ctu_ch2_trig_o,
	// switches, blanks, network
	input  wire logic            [7:0]  switches_i,
	input  wire logic                   frame_blank_i,
	input  wire logic                   line_blank_i,
	input  wire logic            [2:0]  net_status_i,
	output logic                        ctu_ch4_clk_o,
	output logic                        net_ctrl_o,
	// memory mapping
	input  wire logic            [1:0]  cpu_addr_top_i,
	output logic                 [3:0]  mapped_addr_o,
	output logic                 [1:0]  page_select_o,
	output logic                        single_step_irq_enable_o,
	// user parallel port
	input  wire logic            [7:0]  user_data_i,
	input  wire logic                   user_strobe_i,
	input  wire logic                   user_soft_handshake_in_i,
	output logic                        user_busy_o,
	output logic                 [2:0]  user_soft_handshake_out_o,
	// cassette
	input  wire logic                   ctu_ch1_out_i,
	input  wire logic                   cassette_level_in_i,
	input  wire logic                   cassette_data_in_i,
	output logic                        cassette_out_o,
	output logic                 [1:0]  cassette_mode_o,
	// joystick, serial, display
	input  wire logic            [1:0]  joystick_button_i,
	input  wire logic                   soft_serial_rx_i,
	input  wire logic                   soft_serial_cts_i,
	output logic                 [1:0]  joystick_timer_o,
	output logic                        soft_serial_tx_o,
	output logic                        loudspeaker_out_o,
	output logic                        alt_charset_o,
	output logic                        col80_select_o
);
	localparam int JW = $clog2(JOY_CYC + 1);

	// pin samples, two stages each
	typedef struct packed {
		logic [7:0] kcode;
		logic       kstb;
		logic [7:0] sw;
		logic       fb;
		logic       lb;
		logic [2:0] net;
		logic [7:0] udata;
		logic       ustb;
		logic       uhs;
		logic       cas1;
		logic       clev;
		logic       cdat;
		logic [1:0] jb;
		logic       rx;
		logic       cts;
	} iocsp_pins_t;

	typedef struct packed {
		iocsp_pins_t       s1;
		iocsp_pins_t       s2;
		logic              kstb_prev;
		logic              ustb_prev;
		logic              cas1_prev;
		logic              cas_div;
		logic              kbd_ready;
		logic              user_ready;
		logic [7:0]        user_latch;
		logic [7:0]        sysctl;
		logic [7:0]        periph;
		logic [3:0]        map0;
		logic [3:0]        map1;
		logic [3:0]        map2;
		logic [3:0]        map3;
		logic [1:0]        mono_on;
		logic [JW-1:0]     mono_cnt;
		logic              joystick_trigger_prev;
		logic [7:0]        rdata;
		logic              rvalid;
		iocsp_pkg::iocsp_sel_t sel;
		logic              ch2;
		logic              ch4;
		logic [3:0]        maddr;
		logic              kbd_rst;
		logic              cas_out;
	} iocsp_state_t;

	iocsp_state_t s_q;
	iocsp_state_t s_d;
	iocsp_pins_t  pins_now;

	// keyboard code queue between strobe capture and data port reads
	logic       kf_in_ready;
	logic       kf_out_valid;
	logic [7:0] kf_out_data;
	logic       kf_push;
	logic       kf_pop;
	logic [7:0] a_lo;
	logic       rd_kbd;
	logic       rd_user;
	logic       kstb_rise;
	logic       ustb_rise;

	assign pins_now = '{kcode: kbd_code_i, kstb: kbd_strobe_i,
		sw: switches_i, fb: frame_blank_i, lb: line_blank_i,
		net: net_status_i, udata: user_data_i, ustb: user_strobe_i,
		uhs: user_soft_handshake_in_i, cas1: ctu_ch1_out_i,
		clev: cassette_level_in_i, cdat: cassette_data_in_i,
		jb: joystick_button_i, rx: soft_serial_rx_i,
		cts: soft_serial_cts_i};

	assign a_lo      = bus_i.addr[7:0];
	assign rd_kbd    = bus_i.rd && (a_lo == iocsp_pkg::ADDR_KBD_DATA);
	assign rd_user   = bus_i.rd && (a_lo == iocsp_pkg::ADDR_USER_PORT);
	assign kstb_rise = s_q.s2.kstb && !s_q.kstb_prev;
	assign ustb_rise = s_q.s2.ustb && !s_q.ustb_prev;
	// codes are queued as-is, 6 id + spare + direction bit
	assign kf_push   = kstb_rise && !s_q.kbd_rst;
	assign kf_pop    = rd_kbd && kf_out_valid;

	iocsp_fifo #(
		.WIDTH (8),
		.DEPTH (KFIFO_DEPTH)
	) u_kfifo (
		.clk_i       (clk_i),
		.reset_n_i   (reset_n_i),
		.in_valid_i  (kf_push),
		.in_ready_o  (kf_in_ready),
		.in_data_i   (s_q.s2.kcode),
		.out_valid_o (kf_out_valid),
		.out_ready_i (kf_pop),
		.out_data_o  (kf_out_data)
	);

	// next-state logic for the whole port bank
	always_comb begin
		s_d = s_q;
		s_d.s1 = pins_now;
		s_d.s2 = s_q.s1;
		s_d.kstb_prev  = s_q.s2.kstb;
		s_d.ustb_prev  = s_q.s2.ustb;
		s_d.cas1_prev  = s_q.s2.cas1;
		s_d.joystick_trigger_prev = s_q.periph[4];
		s_d.rvalid     = bus_i.rd;
		s_d.rdata      = 8'h00;
		// chip selects decoded on the low address byte
		s_d.sel.vdu = (bus_i.rd || bus_i.wr) &&
			(a_lo <= iocsp_pkg::ADDR_VDU_LAST);
		s_d.sel.ctu = (bus_i.rd || bus_i.wr) &&
			(a_lo >= iocsp_pkg::ADDR_CTU_FIRST) &&
			(a_lo <= iocsp_pkg::ADDR_CTU_LAST);
		s_d.sel.ser = (bus_i.rd || bus_i.wr) &&
			(a_lo >= iocsp_pkg::ADDR_SER_FIRST) &&
			(a_lo <= iocsp_pkg::ADDR_SER_LAST);
		// strobe pulse to channel 2 for each press or release
		s_d.ch2 = kf_push;
		// frame blank clocks channel 4 for key repeat
		s_d.ch4 = s_q.s2.fb;
		// cassette divide-by-two on channel 1 rising edges
		if (s_q.s2.cas1 && !s_q.cas1_prev)
			s_d.cas_div = !s_q.cas_div;
		// ready set by strobe; set beats a same-cycle clear
		if (kf_push)
			s_d.kbd_ready = 1'b1;
		else if (rd_kbd)
			s_d.kbd_ready = 1'b0;
		// user port: transparent while strobe low, latch on rise
		if (!s_q.s2.ustb)
			s_d.user_latch = s_q.s2.udata;
		if (ustb_rise) begin
			s_d.user_latch = s_q.s2.udata;
			s_d.user_ready = 1'b1;
		end else if (rd_user) begin
			s_d.user_ready = 1'b0;
		end
		// monostables: rising trigger restarts both timers
		if (s_q.periph[4] && !s_q.joystick_trigger_prev) begin
			s_d.mono_on  = 2'b11;
			s_d.mono_cnt = JW'(JOY_CYC - 1);
		end else if (s_q.mono_cnt != '0) begin
			s_d.mono_cnt = s_q.mono_cnt - 1'b1;
		end else begin
			s_d.mono_on = 2'b00;
		end
		// register writes
		if (bus_i.wr) begin
			unique case (a_lo)
				iocsp_pkg::ADDR_SWITCH_MAP: begin
					// entry chosen by upper address byte
					unique case (bus_i.addr[9:8])
						2'd0: s_d.map0 = bus_i.wdata[3:0];
						2'd1: s_d.map1 = bus_i.wdata[3:0];
						2'd2: s_d.map2 = bus_i.wdata[3:0];
						2'd3: s_d.map3 = bus_i.wdata[3:0];
					endcase
				end
				iocsp_pkg::ADDR_SYS_CTRL:
					s_d.sysctl = bus_i.wdata;
				iocsp_pkg::ADDR_PERIPH:
					s_d.periph = bus_i.wdata;
				default: ;
			endcase
		end
		// register reads, answered one cycle later
		if (bus_i.rd) begin
			unique case (a_lo)
				iocsp_pkg::ADDR_SWITCH_MAP:
					s_d.rdata = s_q.s2.sw;
				iocsp_pkg::ADDR_SYS_CTRL:
					s_d.rdata = {s_q.s2.net, s_q.user_ready,
						s_q.s2.uhs, s_q.kbd_ready,
						s_q.s2.fb, s_q.s2.lb};
				iocsp_pkg::ADDR_PERIPH:
					s_d.rdata = {s_q.s2.jb[1], s_q.s2.jb[0],
						s_q.mono_on[0], s_q.mono_on[1],
						s_q.s2.rx, s_q.s2.cts,
						s_q.s2.clev, s_q.s2.cdat};
				iocsp_pkg::ADDR_KBD_DATA:
					// empty queue reads zero, not a stale word
					s_d.rdata = kf_out_valid ? kf_out_data : 8'h00;
				iocsp_pkg::ADDR_USER_PORT:
					s_d.rdata = s_q.user_latch;
				default:
					s_d.rdata = 8'h00;
			endcase
		end
		// lookup of mapped address from cpu address top bits
		unique case (cpu_addr_top_i)
			2'd0: s_d.maddr = s_q.map0;
			2'd1: s_d.maddr = s_q.map1;
			2'd2: s_d.maddr = s_q.map2;
			2'd3: s_d.maddr = s_q.map3;
		endcase
		// a one in bit 6 releases the keyboard reset
		s_d.kbd_rst = !s_d.sysctl[iocsp_pkg::SC_KBRST_BIT];
		// gated output registered so the pin comes from a flop
		s_d.cas_out = s_d.cas_div && !s_d.periph[0];
	end

	// one register for all state; keyboard reset and map 0 on reset
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_q        <= '0;
			s_q.sysctl <= iocsp_pkg::SC_RESET;
			s_q.periph <= iocsp_pkg::PERIPH_RESET;
			s_q.kbd_rst <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from state flip-flops
	assign rdata_o        = s_q.rdata;
	assign rdata_valid_o  = s_q.rvalid;
	assign sel_o          = s_q.sel;
	assign kbd_reset_o    = s_q.kbd_rst;
	assign ctu_ch2_trig_o = s_q.ch2;
	assign ctu_ch4_clk_o  = s_q.ch4;
	assign net_ctrl_o     = s_q.sysctl[iocsp_pkg::SC_NET_BIT];
	assign mapped_addr_o  = s_q.maddr;
	assign page_select_o  = s_q.sysctl[iocsp_pkg::SC_PAGE_LSB +: 2];
	assign single_step_irq_enable_o =
		s_q.sysctl[iocsp_pkg::SC_SSTEP_BIT];
	assign user_busy_o    = s_q.user_ready;  // busy mirrors ready
	assign user_soft_handshake_out_o =
		s_q.sysctl[iocsp_pkg::SC_HS_LSB +: 3];
	// forced low while write enable bit is one
	assign cassette_out_o  = s_q.cas_out;
	assign cassette_mode_o = s_q.periph[2:1];
	assign joystick_timer_o  = s_q.mono_on;
	assign soft_serial_tx_o  = s_q.periph[3];
	assign loudspeaker_out_o = s_q.periph[5];
	assign alt_charset_o     = s_q.periph[6];
	assign col80_select_o    = s_q.periph[7];
endmodule // iocsp_top
`default_nettype wire

/* File: iocsp_pkg.sv */
`default_nettype none
package iocsp_pkg;
	// port addresses on the low i/o address byte
	localparam logic [7:0] ADDR_SWITCH_MAP = 8'h18;
	localparam logic [7:0] ADDR_SYS_CTRL   = 8'h19;
	localparam logic [7:0] ADDR_PERIPH     = 8'h1A;
	localparam logic [7:0] ADDR_KBD_DATA   = 8'h1B;
	localparam logic [7:0] ADDR_USER_PORT  = 8'h1D;
	localparam logic [7:0] ADDR_VDU_LAST   = 8'h17;
	localparam logic [7:0] ADDR_CTU_FIRST  = 8'h20;
	localparam logic [7:0] ADDR_CTU_LAST   = 8'h23;
	localparam logic [7:0] ADDR_SER_FIRST  = 8'h24;
	localparam logic [7:0] ADDR_SER_LAST   = 8'h27;
	// system control bit positions
	localparam int SC_NET_BIT    = 7;
	localparam int SC_KBRST_BIT  = 6;
	localparam int SC_HS_LSB     = 3;
	localparam int SC_SSTEP_BIT  = 2;
	localparam int SC_PAGE_LSB   = 0;
	// reset value of system control: bit 6 low holds keyboard reset,
	// pages zero; software writes a one to bit 6 to let keys through
	localparam logic [7:0] SC_RESET     = 8'h00;
	localparam logic [7:0] PERIPH_RESET = 8'h00;
	localparam int KEY_ID_BITS = 6;
	// monostable nominal time and resulting count at 20 MHz
	localparam int JOY_MONO_US  = 1000;
	localparam int CLK_MHZ      = 20;
	localparam int JOY_MONO_CYC = JOY_MONO_US * CLK_MHZ;
	// cassette tone division
	localparam int CAS_DIV_HIGH = 26;
	localparam int CAS_DIV_LOW  = 52;

	// host i/o bus request
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        rd;
		logic        wr;
	} iocsp_bus_t;

	// device-select strobes
	typedef struct packed {
		logic vdu;
		logic ctu;
		logic ser;
	} iocsp_sel_t;
endpackage
`default_nettype wire

/* File: iocsp_fifo.sv */
`timescale 1ns/1ns
`default_nettype none
module iocsp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             reset_n_i,
	// fill side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// drain side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
	} iocsp_fifo_st_t;
	iocsp_fifo_st_t   s_q;
	iocsp_fifo_st_t   s_d;
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic             push;
	logic             pop;

	assign in_ready_o  = (s_q.cnt != DEPTH[AW:0]);
	assign out_valid_o = (s_q.cnt != '0);
	assign out_data_o  = mem_q[s_q.rp];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	// pointer and count update
	always_comb begin
		s_d = s_q;
		if (push)
			s_d.wp = (s_q.wp == AW'(DEPTH - 1)) ? '0 : s_q.wp + 1'b1;
		if (pop)
			s_d.rp = (s_q.rp == AW'(DEPTH - 1)) ? '0 : s_q.rp + 1'b1;
		if (push && !pop)
			s_d.cnt = s_q.cnt + 1'b1;
		else if (pop && !push)
			s_d.cnt = s_q.cnt - 1'b1;
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// storage has no reset; valid gating hides stale words
	always_ff @(posedge clk_i) begin
		if (push)
			mem_q[s_q.wp] <= in_data_i;
	end
endmodule // iocsp_fifo
`default_nettype wire

/* File: iocsp_host.sv */
`timescale 1ns/1ns
`default_nettype none
module iocsp_host (
	// clock
	input  wire logic                 clk_i,
	// request toward the device
	output var iocsp_pkg::iocsp_bus_t bus_o,
	// read answer
	input  wire logic           [7:0] rdata_i,
	input  wire logic                 rdata_valid_i
);
	// idle bus; released lines show inverted values so stale data never passes
	initial bus_o = '0;
	// one-cycle write, held from one edge to the edge that takes it
	task io_wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge clk_i);
		bus_o <= '{addr: a, wdata: v, rd: 1'b0, wr: 1'b1};
		@(posedge clk_i);
		bus_o <= '{addr: ~a, wdata: ~v, rd: 1'b0, wr: 1'b0};
		#1;
	endtask
	// one-cycle read; a missing valid gives unknown data on purpose
	task io_rd(input logic [15:0] a, output logic [7:0] v);
		@(posedge clk_i);
		bus_o <= '{addr: a, wdata: 8'h00, rd: 1'b1, wr: 1'b0};
		@(posedge clk_i);
		bus_o <= '{addr: ~a, wdata: 8'hFF, rd: 1'b0, wr: 1'b0};
		#1;
		v = rdata_valid_i ? rdata_i : 8'hXX;
	endtask
endmodule // iocsp_host
`default_nettype wire

/* File: iocsp_top_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module iocsp_properties (
	// clock and reset
	input wire logic                  clk_i,
	input wire logic                  reset_n_i,
	// host bus
	input wire iocsp_pkg::iocsp_bus_t bus_i,
	input wire logic            [7:0] rdata_o,
	input wire logic                  rdata_valid_o,
	input wire iocsp_pkg::iocsp_sel_t sel_o,
	// outputs under watch
	input wire logic                  kbd_reset_o,
	input wire logic                  ctu_ch2_trig_o,
	input wire logic            [1:0] page_select_o,
	input wire logic                  net_ctrl_o,
	input wire logic                  cassette_out_o,
	input wire logic                  loudspeaker_out_o,
	input wire logic                  col80_select_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	// a host access of either kind to one low address
	sequence s_acc(logic [7:0] a);
		(bus_i.rd || bus_i.wr) && bus_i.addr[7:0] == a;
	endsequence
	sequence s_wr(logic [7:0] a);
		bus_i.wr && bus_i.addr[7:0] == a;
	endsequence
	sysctl_write_a: assert property (s_wr(8'h19) |=>
		{net_ctrl_o, kbd_reset_o, page_select_o} ==
		{$past(bus_i.wdata[7]), !$past(bus_i.wdata[6]),
		$past(bus_i.wdata[1:0])})
		else $error("system control write not applied");
	periph_write_a: assert property (s_wr(8'h1A) |=>
		col80_select_o == $past(bus_i.wdata[7]) &&
		loudspeaker_out_o == $past(bus_i.wdata[5]))
		else $error("peripheral write not applied");
	cas_gate_a: assert property (s_wr(8'h1A) ##0 bus_i.wdata[0]
		|=> !cassette_out_o) else $error("cassette out not gated");
	unmapped_rd_a: assert property (bus_i.rd && bus_i.addr[7:0] == 8'h1C
		|=> rdata_valid_o && rdata_o == 8'h00)
		else $error("unmapped read not zero");
	vdu_sel_a: assert property (s_acc(8'h05) |=> sel_o.vdu)
		else $error("display select missing");
	ctu_sel_a: assert property (s_acc(8'h21) |=> sel_o.ctu && !sel_o.ser)
		else $error("counter select wrong");
	ser_sel_a: assert property (s_acc(8'h26) |=> sel_o.ser && !sel_o.ctu)
		else $error("serial select wrong");
	trig_pulse_a: assert property ($rose(ctu_ch2_trig_o) |=>
		!ctu_ch2_trig_o) else $error("key trigger longer than one cycle");
	reset_state_a: assert property ($rose(reset_n_i) |->
		kbd_reset_o && page_select_o == 2'b00)
		else $error("wrong state after reset");
endmodule // iocsp_properties
bind iocsp_top iocsp_properties u_props (.clk_i(clk_i),
	.reset_n_i(reset_n_i), .bus_i(bus_i), .rdata_o(rdata_o),
	.rdata_valid_o(rdata_valid_o), .sel_o(sel_o),
	.kbd_reset_o(kbd_reset_o), .ctu_ch2_trig_o(ctu_ch2_trig_o),
	.page_select_o(page_select_o), .net_ctrl_o(net_ctrl_o),
	.cassette_out_o(cassette_out_o),
	.loudspeaker_out_o(loudspeaker_out_o),
	.col80_select_o(col80_select_o));
`default_nettype wire

/* File: io_control_status_ports_test.sv */
`timescale 1ns/1ns
`default_nettype none
module io_control_status_ports_test;
	logic clk_i, reset_n_i, rdata_valid_o, kbd_strobe_i, kbd_reset_o;
	iocsp_pkg::iocsp_bus_t bus_i;
	logic [7:0] rdata_o, kbd_code_i, switches_i, user_data_i, d;
	logic [3:0] mapped_addr_o;
	logic [2:0] net_status_i, user_soft_handshake_out_o;
	logic [1:0] cpu_addr_top_i, page_select_o, cassette_mode_o;
	logic [1:0] joystick_button_i, joystick_timer_o;
	logic frame_blank_i, line_blank_i, ctu_ch4_clk_o, net_ctrl_o, c0;
	logic single_step_irq_enable_o, user_strobe_i, user_busy_o;
	logic user_soft_handshake_in_i, ctu_ch1_out_i, cassette_level_in_i;
	logic cassette_data_in_i, cassette_out_o, soft_serial_rx_i;
	logic soft_serial_cts_i, soft_serial_tx_o, loudspeaker_out_o;
	logic alt_charset_o, col80_select_o;
	int mismatches, checked, cyc;
	// short monostable keeps the joystick check brief
	iocsp_top #(.JOY_CYC(10)) DUT (.clk_i, .reset_n_i, .bus_i, .rdata_o,
		.rdata_valid_o, .sel_o(), .kbd_code_i, .kbd_strobe_i, .kbd_reset_o,
		.ctu_ch2_trig_o(), .switches_i, .frame_blank_i, .line_blank_i,
		.net_status_i, .ctu_ch4_clk_o, .net_ctrl_o, .cpu_addr_top_i,
		.mapped_addr_o, .page_select_o, .single_step_irq_enable_o,
		.user_data_i, .user_strobe_i, .user_soft_handshake_in_i, .user_busy_o,
		.user_soft_handshake_out_o, .ctu_ch1_out_i, .cassette_level_in_i,
		.cassette_data_in_i, .cassette_out_o, .cassette_mode_o,
		.joystick_button_i, .soft_serial_rx_i, .soft_serial_cts_i,
		.joystick_timer_o, .soft_serial_tx_o, .loudspeaker_out_o,
		.alt_charset_o, .col80_select_o);
	iocsp_host host (.clk_i, .bus_o(bus_i), .rdata_i(rdata_o),
		.rdata_valid_i(rdata_valid_o));
	// clock and hang guard
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			report_and_stop();
		end
	end
	task report_and_stop();
		if (mismatches == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("Error %0t got %h exp %h", $time, g, e);
		end
	endtask
	task wait_clk(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// strobe held long enough to pass the two-stage synchroniser
	task kstrobe(input logic [7:0] c);
		@(posedge clk_i);
		kbd_code_i <= c;
		kbd_strobe_i <= 1'b1;
		wait_clk(3);
		kbd_strobe_i <= 1'b0;
		wait_clk(3);
	endtask
	task t_reset();
		chk({5'h00, kbd_reset_o, page_select_o}, 8'h04);
		kstrobe(8'h3F);
		host.io_wr(16'h0019, 8'hED);
		chk({net_ctrl_o, kbd_reset_o, user_soft_handshake_out_o,
			single_step_irq_enable_o, page_select_o}, 8'hAD);
	endtask
	task t_map();
		for (int i = 0; i < 4; i++) host.io_wr({6'h00, 2'(i), 8'h18},
			{4'hF, 4'(i * 3 + 1)});
		for (int i = 0; i < 4; i++) begin
			cpu_addr_top_i <= 2'(i);
			wait_clk(3);
			chk({4'h0, mapped_addr_o}, {4'h0, 4'(i * 3 + 1)});
		end
	endtask
	task t_inputs();
		switches_i <= 8'hA5;
		frame_blank_i <= 1'b1;
		wait_clk(4);
		host.io_rd(16'h0018, d);
		chk(d, 8'hA5);
		host.io_rd(16'h0019, d);
		chk(d, 8'hAB);
		chk({7'h00, ctu_ch4_clk_o}, 8'h01);
		host.io_rd(16'h001A, d);
		chk(d, 8'h4A);
		host.io_rd(16'h001C, d);
		chk(d, 8'h00);
		host.io_rd(16'h0005, d);
		host.io_rd(16'h0021, d);
		host.io_rd(16'h0026, d);
	endtask
	// nine codes into an eight-deep queue: the last one is refused
	task t_kbd();
		for (int i = 0; i < 9; i++) kstrobe({2'b11, 6'(i * 7)});
		host.io_rd(16'h0019, d);
		chk(d & 8'h04, 8'h04);
		for (int i = 0; i < 9; i++) begin
			host.io_rd(16'h001B, d);
			chk(d, i < 8 ? {2'b11, 6'(i * 7)} : 8'h00);
		end
		host.io_rd(16'h0019, d);
		chk(d & 8'h04, 8'h00);
	endtask
	task t_user();
		user_data_i <= 8'h3C;
		wait_clk(4);
		host.io_rd(16'h001D, d);
		chk(d, 8'h3C);
		user_data_i <= 8'h5A;
		wait_clk(4);
		user_strobe_i <= 1'b1;
		wait_clk(4);
		user_data_i <= 8'h00;
		wait_clk(4);
		chk({7'h00, user_busy_o}, 8'h01);
		host.io_rd(16'h001D, d);
		chk(d, 8'h5A);
		chk({7'h00, user_busy_o}, 8'h00);
		user_strobe_i <= 1'b0;
	endtask
	task t_periph();
		host.io_wr(16'h001A, 8'hE6);
		chk({col80_select_o, alt_charset_o, loudspeaker_out_o, 1'b0,
			soft_serial_tx_o, cassette_mode_o, 1'b0}, 8'hE6);
		c0 = cassette_out_o;
		ctu_ch1_out_i <= 1'b1;
		wait_clk(4);
		ctu_ch1_out_i <= 1'b0;
		wait_clk(4);
		chk({7'h00, cassette_out_o}, {7'h00, ~c0});
		host.io_wr(16'h001A, 8'h11);
		wait_clk(3);
		chk({6'h00, joystick_timer_o}, 8'h03);
		chk({7'h00, cassette_out_o}, 8'h00);
		wait_clk(20);
		chk({6'h00, joystick_timer_o}, 8'h00);
	endtask
	// main sequence
	initial begin
		{reset_n_i, kbd_code_i, kbd_strobe_i, switches_i, user_data_i} = '0;
		{frame_blank_i, cpu_addr_top_i, user_strobe_i, ctu_ch1_out_i} = '0;
		{cassette_data_in_i, soft_serial_cts_i} = '0;
		{line_blank_i, user_soft_handshake_in_i, cassette_level_in_i} = '1;
		{net_status_i, joystick_button_i, soft_serial_rx_i} = 6'h2B;
		wait_clk(8);
		reset_n_i <= 1'b1;
		t_reset();
		t_map();
		t_inputs();
		t_kbd();
		t_user();
		t_periph();
		report_and_stop();
	end
endmodule // io_control_status_ports_test
`default_nettype wire
